// [pkg/stagc_regs.svh]
// Command codes, phase selector, answer lengths and reset values of the status command block.
// Assumes a PMBus transaction engine outside that decodes command codes.
`ifndef STAGC_REGS_SVH
`define STAGC_REGS_SVH

// Command codes answered by this block.
`define STAGC_CMD_SNAPSHOT 8'hDB
`define STAGC_CMD_PHASE_SUM 8'hDC
`define STAGC_CMD_PG_SETUP 8'hE3

// Phase selector value that means every phase at once.
`define STAGC_PHASE_ALL 8'hFF

// Answer lengths in bytes.
`define STAGC_SNAP_BYTES 3'h7
`define STAGC_WORD_BYTES 3'h2

// Reset values; the power-good word is normally loaded from storage.
`define STAGC_PG_RESET 16'h0000
`define STAGC_PH_RESET 4'h0

`endif

// [pkg/stagc_pkg.sv]
// Types shared by the status command block.
// Assumes the constants header is included by the design module itself.
package stagc_pkg;

    // Answer state, one-hot.
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b01,
        ST_REPLY = 2'b10
    } stagc_state_t;

    // Complete state of the block.
    typedef struct packed {
        stagc_state_t state;
        logic [55:0] rsp_data;
        logic [2:0] rsp_bytes;
        logic rsp_valid;
        logic ivc_set;
        logic [3:0] ph_latch;
        logic [15:0] pg_setup;
    } stagc_reg_t;

endpackage

// [rtl/stagc_status_cmds.sv]
// Status snapshot, phase fault summary and power-good setup commands.
// Assumes a PMBus engine on the same clock hands over decoded requests
// and takes answers back; status bytes arrive from same-clock logic.
//
// Notes on behaviour
// - Command DBh answers a seven-byte block read.
// - Snapshot bytes: manufacturer high down to output-voltage low.
// - Writing read-only command flags invalid command.
// - Snapshot write never clears any status bit.
// - All-phase select returns per-phase fault mask.
// - Single phase: bit zero shows any status.
// - Unused phases in the all-phase mask and bits fifteen-four read zero.
// - Bits three to zero map phases three-zero.
// - DCh takes word writes and reads, live.
// - Power-good word writable only with conversion off.
`include "stagc_regs.svh"

module stagc_status_cmds
    import stagc_pkg::*;
(
    input wire logic clk, // 40 MHz system clock.
    input wire logic rst_b, // Asynchronous reset, active low.
    input wire logic req_valid, // One-cycle request strobe.
    input wire logic req_write, // High for a write, low for a read.
    input wire logic [7:0] req_code, // Command code of the request.
    input wire logic [15:0] req_wdata, // Write word of the request.
    input wire logic [7:0] phase_sel, // Current phase selector.
    input wire logic conv_enable, // High while conversion is enabled.
    input wire logic [3:0] phase_used, // Phases assigned and enabled.
    input wire logic [3:0] phase_fault, // Fault events per phase.
    input wire logic [7:0] stat_mfr, // Manufacturer status byte.
    input wire logic [7:0] stat_other, // Other status byte.
    input wire logic [7:0] stat_cml, // Communication status byte.
    input wire logic [7:0] stat_temp, // Temperature status byte.
    input wire logic [7:0] stat_input, // Input status byte.
    input wire logic [7:0] stat_iout, // Output current status byte.
    input wire logic [7:0] stat_vout, // Output voltage status byte.
    output logic rsp_valid, // One-cycle read answer strobe.
    output logic [55:0] rsp_data, // Answer data, low byte first on wire.
    output logic [2:0] rsp_bytes, // Answer length in bytes.
    output logic ivc_set, // Pulse: set invalid-command flags.
    output logic [15:0] pg_setup // Power-good setup word.
);

    ////////////////////////////////////////////////////////////////////////
    // State registers and combinational helpers.

    stagc_reg_t r; // Present state.
    stagc_reg_t next_r; // Next state.
    logic take; // A request is accepted this cycle.
    logic any_status; // The active phase reports some status bit.
    logic [3:0] ph_clear; // Fault flags that the host clears.

    // Requests are taken only in idle, so an answer is never overrun.
    // Limitation: a request in the answer cycle is dropped without trace,
    // so the engine must leave one idle cycle after every read.
    assign take = req_valid && (r.state == ST_IDLE);
    assign any_status = |{stat_mfr, stat_other, stat_cml, stat_temp,
                          stat_input, stat_iout, stat_vout};

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic.

    // One pass decides the answer and every register update.
    always_comb begin
        next_r = r;
        next_r.rsp_valid = 1'b0;
        next_r.ivc_set = 1'b0;
        next_r.state = ST_IDLE;
        ph_clear = 4'h0;
        if (take && req_write && req_code == `STAGC_CMD_PHASE_SUM) begin
            ph_clear = req_wdata[3:0];
        end
        // A fault arriving with its clear survives the clear.
        next_r.ph_latch = (r.ph_latch & ~ph_clear) | phase_fault;
        if (take) begin
            unique case (req_code)
                `STAGC_CMD_SNAPSHOT: begin
                    if (req_write) begin
                        // Read-only: flag it, touch no status bit.
                        next_r.ivc_set = 1'b1;
                    end else begin
                        // Whole snapshot taken at the same edge.
                        next_r.rsp_data = {stat_mfr, stat_other,
                                           stat_cml, stat_temp,
                                           stat_input, stat_iout,
                                           stat_vout};
                        next_r.rsp_bytes = `STAGC_SNAP_BYTES;
                        next_r.rsp_valid = 1'b1;
                        next_r.state = ST_REPLY;
                    end
                end
                `STAGC_CMD_PHASE_SUM: begin
                    if (!req_write) begin
                        next_r.rsp_data = 56'h0;
                        if (phase_sel == `STAGC_PHASE_ALL) begin
                            // Unused phases masked to zero.
                            next_r.rsp_data[3:0] = r.ph_latch
                                & phase_used;
                        end else begin
                            next_r.rsp_data[0] = any_status;
                        end
                        next_r.rsp_bytes = `STAGC_WORD_BYTES;
                        next_r.rsp_valid = 1'b1;
                        next_r.state = ST_REPLY;
                    end
                end
                `STAGC_CMD_PG_SETUP: begin
                    if (req_write) begin
                        if (conv_enable) begin
                            // Read-only while converting.
                            next_r.ivc_set = 1'b1;
                        end else begin
                            next_r.pg_setup = req_wdata;
                        end
                    end else begin
                        next_r.rsp_data = {40'h0, r.pg_setup};
                        next_r.rsp_bytes = `STAGC_WORD_BYTES;
                        next_r.rsp_valid = 1'b1;
                        next_r.state = ST_REPLY;
                    end
                end
                default: begin
                    // Other codes belong to other blocks.
                    next_r.state = ST_IDLE;
                end
            endcase
        end
    end

    // State register; reset gives idle and the header reset values.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            r <= '{state: ST_IDLE, rsp_data: 56'h0, rsp_bytes: 3'h0,
                   rsp_valid: 1'b0, ivc_set: 1'b0,
                   ph_latch: `STAGC_PH_RESET, pg_setup: `STAGC_PG_RESET};
        end else begin
            r <= next_r;
        end
    end

    assign rsp_valid = r.rsp_valid;
    assign rsp_data = r.rsp_data;
    assign rsp_bytes = r.rsp_bytes;
    assign ivc_set = r.ivc_set;
    assign pg_setup = r.pg_setup;

    ////////////////////////////////////////////////////////////////////////
    // Assertions and covers.

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    logic rd_snap; // Snapshot read taken.
    logic wr_snap; // Snapshot write taken.
    logic rd_sum; // Summary read taken.
    assign rd_snap = take && !req_write && req_code == `STAGC_CMD_SNAPSHOT;
    assign wr_snap = take && req_write && req_code == `STAGC_CMD_SNAPSHOT;
    assign rd_sum = take && !req_write && req_code == `STAGC_CMD_PHASE_SUM;

    snap_len_a: assert property (rd_snap |=> rsp_valid
        && rsp_bytes == 3'h7 ##1 !rsp_valid)
        else $error("snapshot answer length or strobe wrong");
    snap_order_a: assert property (rd_snap |=> rsp_data ==
        {$past(stat_mfr), $past(stat_other), $past(stat_cml),
         $past(stat_temp), $past(stat_input), $past(stat_iout),
         $past(stat_vout)})
        else $error("snapshot byte order wrong");
    snap_ivc_a: assert property (wr_snap |=> ivc_set && !rsp_valid)
        else $error("snapshot write did not flag invalid command");
    snap_keep_a: assert property (wr_snap && phase_fault == 4'h0
        |=> r.ph_latch == $past(r.ph_latch))
        else $error("snapshot write changed fault flags");
    sum_all_a: assert property (rd_sum && phase_sel == 8'hFF
        |=> rsp_data[3:0] == ($past(r.ph_latch) & $past(phase_used)))
        else $error("all-phase summary mask wrong");
    sum_one_a: assert property (rd_sum && phase_sel != 8'hFF
        |=> rsp_data[0] == $past(any_status) && rsp_data[3:1] == 3'h0)
        else $error("single-phase summary wrong");
    sum_resv_a: assert property (rd_sum |=> rsp_data[55:4] == 52'h0)
        else $error("summary reserved bits not zero");
    ph_set_a: assert property (phase_fault[3] |=> r.ph_latch[3])
        else $error("phase three fault lost");
    ph_clr_a: assert property (take && req_write
        && req_code == `STAGC_CMD_PHASE_SUM && req_wdata[0]
        && !phase_fault[0] |=> !r.ph_latch[0])
        else $error("summary write did not clear flag");
    pg_lock_a: assert property (take && req_write && conv_enable
        && req_code == `STAGC_CMD_PG_SETUP
        |=> $stable(pg_setup) && ivc_set)
        else $error("power-good word written while converting");
    pg_wr_a: assert property (take && req_write && !conv_enable
        && req_code == `STAGC_CMD_PG_SETUP
        |=> pg_setup == $past(req_wdata))
        else $error("power-good word not written");
    snap_hold_a: assert property (rd_snap |=> ##1
        $stable(rsp_data))
        else $error("snapshot changed after capture");
    // The answer strobe lasts one cycle, so one read gives one answer.
    rsp_pulse_a: assert property (rsp_valid |=> !rsp_valid)
        else $error("read answer strobe held too long");
    // The invalid-command pulse must not set the flags twice.
    ivc_pulse_a: assert property (ivc_set |=> !ivc_set)
        else $error("invalid-command pulse held too long");
    // A request in the answer cycle must raise no strobe and leave the power-good word alone.
    busy_drop_a: assert property (req_valid && r.state == ST_REPLY
        |=> !rsp_valid && !ivc_set && $stable(pg_setup))
        else $error("request taken while answering");

    ////////////////////////////////////////////////////////////////////////
    // Covers of the main scenarios.

    snap_c: cover property (rd_snap ##1 rsp_valid);
    sum_c: cover property (rd_sum && phase_sel == 8'hFF
        && r.ph_latch != 4'h0);
    pg_c: cover property (take && req_write && conv_enable
        && req_code == `STAGC_CMD_PG_SETUP);
    wr_c: cover property (wr_snap ##1 ivc_set);
    busy_c: cover property (req_valid && r.state == ST_REPLY);

endmodule

// [bench/stagc_host.sv]
// Host model: issues single requests and read-then-write pairs to the status command block.
// Assumes the bench calls xfer and samples answers when it returns.
module stagc_host (
    input wire logic clk, // System clock.
    output logic req_valid, // Request strobe.
    output logic req_write, // Write flag.
    output logic [7:0] req_code, // Command code.
    output logic [15:0] req_wdata // Write word.
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle from time zero, so nothing is taken during reset.
    initial begin
        req_valid = 1'h0;
        req_write = 1'h0;
        req_code = 8'h00;
        req_wdata = 16'h0000;
    end
    // One request, held across one rising edge and then withdrawn.
    // The stale word is inverted so that it can never pass for a value.
    task automatic xfer(input logic w, input logic [7:0] c,
                        input logic [15:0] d);
        @(negedge clk);
        req_valid = 1'h1;
        req_write = w;
        req_code = c;
        req_wdata = d;
        @(negedge clk);
        req_valid = 1'h0;
        req_wdata = ~d;
    endtask
    // A read, then at once a write that falls in the refused answer cycle.
    task automatic xfer_pair(input logic [7:0] c, input logic [7:0] c2,
                             input logic [15:0] d);
        @(negedge clk);
        req_valid = 1'h1;
        req_write = 1'h0;
        req_code = c;
        req_wdata = d;
        @(negedge clk);
        req_write = 1'h1;
        req_code = c2;
        @(negedge clk);
        req_valid = 1'h0;
        req_wdata = ~d;
    endtask
endmodule

// [bench/testbench.sv]
// Self-checking bench for the status command block.
// Assumes the host model and the design sources are compiled first.
`include "stagc_regs.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_b, req_valid, req_write, conv_enable, rsp_valid, ivc_set;
    logic [7:0] req_code, phase_sel;
    logic [15:0] req_wdata, pg_setup, pg_exp, d;
    logic [3:0] phase_used, phase_fault, flags; // Flags: model copy.
    logic [7:0] st [7]; // Status bytes, output voltage at index 0.
    logic [55:0] rsp_data, old;
    logic [2:0] rsp_bytes;
    integer seed = 2331, error_cnt = 0, n_compared = 0, cyc = 0, i;
    stagc_host i_host (.clk(clk), .req_valid(req_valid),
        .req_write(req_write), .req_code(req_code), .req_wdata(req_wdata));
    stagc_status_cmds i_dut (.clk(clk), .rst_b(rst_b),
        .req_valid(req_valid), .req_write(req_write), .req_code(req_code),
        .req_wdata(req_wdata), .phase_sel(phase_sel),
        .conv_enable(conv_enable), .phase_used(phase_used),
        .phase_fault(phase_fault), .stat_mfr(st[6]), .stat_other(st[5]),
        .stat_cml(st[4]), .stat_temp(st[3]), .stat_input(st[2]),
        .stat_iout(st[1]), .stat_vout(st[0]), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .rsp_bytes(rsp_bytes), .ivc_set(ivc_set),
        .pg_setup(pg_setup));
    // Free-running 40 MHz clock.
    initial begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end
    // Hang guard: the run needs well under a thousand cycles.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            close_out();
        end
    end
    function automatic logic [55:0] snap_exp();
        snap_exp = {st[6], st[5], st[4], st[3], st[2], st[1], st[0]};
    endfunction
    // Summary word: masked flags for all phases, else any status bit.
    function automatic logic [55:0] sum_exp();
        if (phase_sel === `STAGC_PHASE_ALL)
            sum_exp = {52'h0, flags & phase_used};
        else
            sum_exp = {55'h0, |snap_exp()};
    endfunction
    task automatic newstat();
        for (int k = 0; k < 7; k++)
            st[k] = 8'($random(seed));
    endtask
    task automatic chk(input string nm, input logic [55:0] e, g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    // Read: answer strobe, length and data one edge after the request.
    task automatic rd(input logic [7:0] c, input logic [55:0] e,
                      input logic [2:0] n);
        i_host.xfer(1'h0, c, 16'h0000);
        chk("rsp_valid", 56'h1, {55'h0, rsp_valid});
        chk("rsp_bytes", {53'h0, n}, {53'h0, rsp_bytes});
        chk("rsp_data", e, rsp_data);
    endtask
    // Write: no read answer, invalid-command pulse only when refused.
    task automatic wr(input logic [7:0] c, input logic [15:0] v,
                      input logic ivc);
        i_host.xfer(1'h1, c, v);
        chk("ivc_set", {55'h0, ivc}, {55'h0, ivc_set});
        chk("rsp_valid", 56'h0, {55'h0, rsp_valid});
        chk("pg_setup", {40'h0, pg_exp}, {40'h0, pg_setup});
    endtask
    task automatic close_out();
        if (error_cnt == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Main sequence: reset, then six kinds of operation with random data.
    initial begin
        rst_b = 1'h0;
        conv_enable = 1'h0;
        phase_used = 4'hF;
        phase_fault = 4'h0;
        phase_sel = 8'hFF;
        flags = 4'h0;
        pg_exp = 16'h0000;
        newstat();
        repeat (12) @(negedge clk);
        rst_b = 1'h1;
        chk("rsp_valid", 56'h0, {55'h0, rsp_valid});
        for (i = 0; i < 60; i++) begin
            newstat();
            phase_used = 4'($random(seed));
            conv_enable = 1'($random(seed));
            d = 16'($random(seed));
            phase_sel = 8'hFF;
            case (i % 6)
                0: begin
                    old = snap_exp();
                    rd(`STAGC_CMD_SNAPSHOT, old, 3'h7);
                    newstat();
                    @(negedge clk);
                    chk("rsp_data", old, rsp_data);
                end
                1: begin
                    wr(`STAGC_CMD_SNAPSHOT, d, 1'h1);
                    rd(`STAGC_CMD_PHASE_SUM, sum_exp(), 3'h2);
                end
                2: begin
                    phase_fault = 4'($random(seed));
                    @(negedge clk);
                    flags = flags | phase_fault;
                    phase_fault = 4'h0;
                    rd(`STAGC_CMD_PHASE_SUM, sum_exp(), 3'h2);
                end
                3: begin
                    phase_sel = {6'h00, 2'($random(seed))};
                    phase_used[phase_sel[1:0]] = 1'h1;
                    rd(`STAGC_CMD_PHASE_SUM, sum_exp(), 3'h2);
                end
                4: begin
                    wr(`STAGC_CMD_PHASE_SUM, d, 1'h0);
                    flags = flags & ~d[3:0];
                    rd(`STAGC_CMD_PHASE_SUM, sum_exp(), 3'h2);
                end
                default: begin
                    if (!conv_enable)
                        pg_exp = d;
                    wr(`STAGC_CMD_PG_SETUP, d, conv_enable);
                    rd(`STAGC_CMD_PG_SETUP, {40'h0, pg_exp}, 3'h2);
                end
            endcase
        end
        // An unknown code must be ignored without any strobe.
        wr(8'h5A, 16'hFFFF, 1'h0);
        // Corner: a write in the cycle right after a read is refused.
        conv_enable = 1'h0;
        i_host.xfer_pair(`STAGC_CMD_SNAPSHOT, `STAGC_CMD_PG_SETUP, ~pg_exp);
        chk("rsp_valid", 56'h0, {55'h0, rsp_valid});
        chk("ivc_set", 56'h0, {55'h0, ivc_set});
        chk("rsp_data", snap_exp(), rsp_data);
        chk("pg_setup", {40'h0, pg_exp}, {40'h0, pg_setup});
        // Mid-run reset: flags and the power-good word return to reset.
        rst_b = 1'h0;
        @(negedge clk);
        rst_b = 1'h1;
        flags = 4'h0;
        pg_exp = `STAGC_PG_RESET;
        chk("rsp_valid", 56'h0, {55'h0, rsp_valid});
        rd(`STAGC_CMD_PHASE_SUM, sum_exp(), 3'h2);
        rd(`STAGC_CMD_PG_SETUP, {40'h0, pg_exp}, 3'h2);
        close_out();
    end
endmodule
